// [include/bgc_pkg.sv]
package bgc_pkg;

    // ------------------------------------------------------------
    // Register offsets in configuration space
    // ------------------------------------------------------------
    localparam logic [7:0] DEV_CTRL_OFS  = 8'h92;
    localparam logic [7:0] DIAG_OFS      = 8'h93;
    localparam logic [7:0] CAP_ID_OFS    = 8'hA0;
    localparam logic [7:0] NEXT_PTR_OFS  = 8'hA1;

    // ------------------------------------------------------------
    // Reset and fixed read values
    // ------------------------------------------------------------
    localparam logic [7:0] DEV_CTRL_RST  = 8'h66;
    localparam logic [7:0] DIAG_RST      = 8'h60;
    localparam logic [7:0] CAP_ID_VAL    = 8'h01;
    localparam logic [7:0] NEXT_PTR_VAL  = 8'h00;
    localparam logic [7:0] DIAG_ONES     = 8'h40;   // Bit 6 always reads 1

    // ------------------------------------------------------------
    // Storage masks: shared bits versus per-function bits
    // ------------------------------------------------------------
    localparam logic [7:0] DEV_GLOBAL_MASK  = 8'h49;   // Bits 6, 3, 0
    localparam logic [7:0] DEV_LOCAL_MASK   = 8'hA6;   // Bits 7, 5, 2, 1
    localparam logic [7:0] DIAG_GLOBAL_MASK = 8'h9E;   // Bits 7, 4, 3, 2, 1
    localparam logic [7:0] DIAG_LOCAL_MASK  = 8'h21;   // Bits 5, 0

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int DEV_HOLD_BIT     = 7;
    localparam int DEV_LOWVOLT_BIT  = 6;
    localparam int DEV_DIAGIO_BIT   = 5;
    localparam int DEV_RSVD_BIT     = 4;
    localparam int DEV_MODE_LSB     = 1;
    localparam int DIAG_IDMASK_BIT  = 7;
    localparam int DIAG_ONE_BIT     = 6;
    localparam int DIAG_CSC_BIT     = 5;
    localparam int DIAG_DLYOFF_BIT  = 4;
    localparam int DIAG_RETRY_BIT   = 3;
    localparam int DIAG_CARDSEL_BIT = 2;
    localparam int DIAG_HOSTSEL_BIT = 1;
    localparam int DIAG_ZVOFF_BIT   = 0;

    // ------------------------------------------------------------
    // Timing counts
    // ------------------------------------------------------------
    localparam logic [6:0] RETRY_LIMIT_SHORT = 7'h10;  // 16
    localparam logic [6:0] RETRY_LIMIT_LONG  = 7'h40;  // 64
    localparam int DISCARD_SHORT_EXP    = 10;
    localparam int DISCARD_LONG_EXP     = 15;
    localparam int DISCARD_SHORT_CYCLES = 1 << DISCARD_SHORT_EXP;
    localparam int DISCARD_LONG_CYCLES  = 1 << DISCARD_LONG_EXP;
    localparam logic [3:0] LEGACY_805_PCI_ROUTE = 4'h0;

    // ------------------------------------------------------------
    // Interrupt signaling modes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        BGC_INT_PAR_PCI = 2'h0,
        BGC_INT_PAR_IRQ = 2'h1,
        BGC_INT_SER_IRQ = 2'h2,
        BGC_INT_SER_ALL = 2'h3
    } bgc_int_mode_type;

endpackage

// [include/bgc_discard_if.sv]
`timescale 1ns/10ps
interface bgc_discard_if;
    logic run;        // Timer counts while high
    logic shortSel;   // High selects the short expiry
    logic expired;    // One-cycle pulse at expiry

    modport ctl (output run, output shortSel, input expired);
    modport tmr (input run, input shortSel, output expired);
endinterface

// [rtl/bgc_discard_timer.sv]
`timescale 1ns/10ps
module bgc_discard_timer #(
    parameter int CNT_W        = 16,
    parameter int SHORT_CYCLES = bgc_pkg::DISCARD_SHORT_CYCLES,
    parameter int LONG_CYCLES  = bgc_pkg::DISCARD_LONG_CYCLES
) (
    input wire logic   mclk,
    input wire logic   rst,
    bgc_discard_if.tmr tif
);
    localparam logic [CNT_W-1:0] SHORT_LAST = CNT_W'(SHORT_CYCLES - 1);
    localparam logic [CNT_W-1:0] LONG_LAST  = CNT_W'(LONG_CYCLES - 1);

    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic             done_reg;
    logic             done_next;
    logic             expired_reg;
    logic             expired_next;
    logic [CNT_W-1:0] lastCount;

    // ------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------
    // Expiry fires once per run; dropping run rearms the timer
    always_comb
    begin
        lastCount    = tif.shortSel ? SHORT_LAST : LONG_LAST;
        cnt_next     = cnt_reg;
        done_next    = done_reg;
        expired_next = 1'b0;
        if (!tif.run)
        begin
            cnt_next  = '0;
            done_next = 1'b0;
        end
        else if (!done_reg)
        begin
            if (cnt_reg >= lastCount)
            begin
                expired_next = 1'b1;
                done_next    = 1'b1;
            end
            else
            begin
                cnt_next = cnt_reg + CNT_W'(1);
            end
        end
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            cnt_reg     <= '0;
            done_reg    <= 1'b0;
            expired_reg <= 1'b0;
        end
        else
        begin
            cnt_reg     <= cnt_next;
            done_reg    <= done_next;
            expired_reg <= expired_next;
        end
    end

    assign tif.expired = expired_reg;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    expire_time_a: assert property (@(posedge mclk) disable iff (rst)
        $rose(expired_reg) |-> $past(cnt_reg) == $past(lastCount))
        else $error("Discard timer expired at the wrong count");
    expire_once_a: assert property (@(posedge mclk) disable iff (rst)
        expired_reg |=> !expired_reg)
        else $error("Discard timer expiry longer than one cycle");
endmodule

// [rtl/bgc_global_config_regs.sv]
`timescale 1ns/10ps
// Summary of operation
// - Hold bit blocks socket power-down in D3
// - Low-voltage force bit sets 3-V capability report
// - Diagnostic I/O bit writable, resets to one
// - Control bit 4 always reads zero
// - Two-bit field selects interrupt signaling scheme
// - Shared bits reachable only via function 0
// - Mask bit forces ID reads to ones
// - Diagnostic bit 6 always reads one
// - Routing bit chooses legacy status-change routing source
// - Diagnostic bit 4 disables delayed transactions
// - Diagnostic bit 3 extends retry latency 16 to 64
// - Card-side discard timer 2^10 or 2^15 clocks
// - Host-side discard timer 2^10 or 2^15 clocks
// - Zoom-video model enabled while its bit is zero
// - Capability identifier byte reads 01h
// - Next-item pointer byte reads zero
module bgc_global_config_regs #(
    parameter int DISCARD_SHORT = bgc_pkg::DISCARD_SHORT_CYCLES,
    parameter int DISCARD_LONG  = bgc_pkg::DISCARD_LONG_CYCLES
) (
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire logic       cfgFunc,
    input  wire logic [7:0] cfgAddr,
    input  wire logic [7:0] cfgWrData,
    input  wire logic       cfgWrEn,
    input  wire logic       cfgRdEn,
    output logic      [7:0] cfgRdData,
    output logic            cfgRdValid,
    output logic            cfgHit,
    input  wire logic [1:0] pwrDownReq,
    input  wire logic [1:0] inD3,
    output logic      [1:0] pwrDownAllow,
    output logic            lowVoltCapable,
    output logic      [1:0] diagIoBit,
    output logic      [1:0] parallelIrqEn,
    output logic      [1:0] serialIrqEn,
    output logic      [1:0] serialPciEn,
    output logic            idReadMask,
    input  wire logic [1:0] legacy803Bit4,
    input  wire logic [3:0] legacy805Hi0,
    input  wire logic [3:0] legacy805Hi1,
    output logic      [1:0] cscToPci,
    output logic            delayedTxnDisable,
    output logic      [6:0] retryLatencyLimit,
    input  wire logic       cardDiscardRun,
    input  wire logic       hostDiscardRun,
    output logic            cardDiscardExpired,
    output logic            hostDiscardExpired,
    output logic      [1:0] zoomVideoModelEnable
);
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Returns {parallel IRQ, serial IRQ, serial PCI}
    function automatic logic [2:0] modeFlags(input logic [1:0] mode);
        logic [2:0] flags;
        flags = 3'h0;
        unique case (bgc_pkg::bgc_int_mode_type'(mode))
            bgc_pkg::BGC_INT_PAR_PCI: flags = 3'h0;
            bgc_pkg::BGC_INT_PAR_IRQ: flags = 3'h4;
            bgc_pkg::BGC_INT_SER_IRQ: flags = 3'h2;
            bgc_pkg::BGC_INT_SER_ALL: flags = 3'h3;
        endcase
        return flags;
    endfunction

    function automatic logic isMapped(input logic [7:0] addr);
        return (addr == bgc_pkg::DEV_CTRL_OFS) || (addr == bgc_pkg::DIAG_OFS) ||
               (addr == bgc_pkg::CAP_ID_OFS) || (addr == bgc_pkg::NEXT_PTR_OFS);
    endfunction

    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------
    logic [1:0][7:0] devLocal_reg;
    logic [1:0][7:0] devLocal_next;
    logic [1:0][7:0] diagLocal_reg;
    logic [1:0][7:0] diagLocal_next;
    logic      [7:0] devGlobal_reg;
    logic      [7:0] devGlobal_next;
    logic      [7:0] diagGlobal_reg;
    logic      [7:0] diagGlobal_next;
    logic      [7:0] rdData_reg;
    logic      [7:0] rdData_next;
    logic            rdValid_reg;
    logic            rdValid_next;
    logic            hit_reg;
    logic            hit_next;

    // Writes: per-function bits land in the addressed function, shared
    // bits only from function 0; fixed bits are masked off here
    always_comb
    begin
        devLocal_next   = devLocal_reg;
        diagLocal_next  = diagLocal_reg;
        devGlobal_next  = devGlobal_reg;
        diagGlobal_next = diagGlobal_reg;
        if (cfgWrEn)
        begin
            if (cfgAddr == bgc_pkg::DEV_CTRL_OFS)
            begin
                devLocal_next[cfgFunc] = cfgWrData & bgc_pkg::DEV_LOCAL_MASK;
                if (!cfgFunc)
                    devGlobal_next = cfgWrData & bgc_pkg::DEV_GLOBAL_MASK;
            end
            else if (cfgAddr == bgc_pkg::DIAG_OFS)
            begin
                diagLocal_next[cfgFunc] = cfgWrData & bgc_pkg::DIAG_LOCAL_MASK;
                if (!cfgFunc)
                    diagGlobal_next = cfgWrData & bgc_pkg::DIAG_GLOBAL_MASK;
            end
        end
    end

    // Read path: one cycle from request to data
    always_comb
    begin
        rdValid_next = cfgRdEn;
        hit_next     = cfgRdEn && isMapped(cfgAddr);
        rdData_next  = rdData_reg;
        if (cfgRdEn)
        begin
            // Unmapped offsets answer zero so an outer decoder may OR us in
            rdData_next = 8'h00;
            if (cfgAddr == bgc_pkg::DEV_CTRL_OFS)
                rdData_next = devLocal_reg[cfgFunc]
                            | (cfgFunc ? 8'h00 : devGlobal_reg);
            else if (cfgAddr == bgc_pkg::DIAG_OFS)
                rdData_next = diagLocal_reg[cfgFunc] | bgc_pkg::DIAG_ONES
                            | (cfgFunc ? 8'h00 : diagGlobal_reg);
            else if (cfgAddr == bgc_pkg::CAP_ID_OFS)
                rdData_next = bgc_pkg::CAP_ID_VAL;
            else if (cfgAddr == bgc_pkg::NEXT_PTR_OFS)
                rdData_next = bgc_pkg::NEXT_PTR_VAL;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            devLocal_reg   <= {2{bgc_pkg::DEV_CTRL_RST & bgc_pkg::DEV_LOCAL_MASK}};
            diagLocal_reg  <= {2{bgc_pkg::DIAG_RST & bgc_pkg::DIAG_LOCAL_MASK}};
            devGlobal_reg  <= bgc_pkg::DEV_CTRL_RST & bgc_pkg::DEV_GLOBAL_MASK;
            diagGlobal_reg <= bgc_pkg::DIAG_RST & bgc_pkg::DIAG_GLOBAL_MASK;
            rdData_reg     <= 8'h00;
            rdValid_reg    <= 1'b0;
            hit_reg        <= 1'b0;
        end
        else
        begin
            devLocal_reg   <= devLocal_next;
            diagLocal_reg  <= diagLocal_next;
            devGlobal_reg  <= devGlobal_next;
            diagGlobal_reg <= diagGlobal_next;
            rdData_reg     <= rdData_next;
            rdValid_reg    <= rdValid_next;
            hit_reg        <= hit_next;
        end
    end

    assign cfgRdData  = rdData_reg;
    assign cfgRdValid = rdValid_reg;
    assign cfgHit     = hit_reg;

    // ------------------------------------------------------------
    // Control outputs
    // ------------------------------------------------------------
    logic [1:0] allow_reg,  allow_next;
    logic       lowVolt_reg, lowVolt_next;
    logic [1:0] diagIo_reg, diagIo_next;
    logic [1:0] parIrq_reg, parIrq_next;
    logic [1:0] serIrq_reg, serIrq_next;
    logic [1:0] serPci_reg, serPci_next;
    logic       idMask_reg, idMask_next;
    logic [1:0] csc_reg,    csc_next;
    logic       dlyOff_reg, dlyOff_next;
    logic [6:0] retry_reg,  retry_next;
    logic [1:0] zvEn_reg,   zvEn_next;
    logic [3:0] legacy805Hi [2];
    logic [2:0] flags;

    // Outputs are registered, so they trail the register write by a cycle
    always_comb
    begin
        legacy805Hi[0] = legacy805Hi0;
        legacy805Hi[1] = legacy805Hi1;
        flags          = 3'h0;
        allow_next     = 2'h0;
        diagIo_next    = 2'h0;
        parIrq_next    = 2'h0;
        serIrq_next    = 2'h0;
        serPci_next    = 2'h0;
        csc_next       = 2'h0;
        zvEn_next      = 2'h0;
        for (int f = 0; f < 2; f++)
        begin
            // A held socket stays powered in D3 for wake events
            allow_next[f] = pwrDownReq[f]
                          & ~(inD3[f] & devLocal_reg[f][bgc_pkg::DEV_HOLD_BIT]);
            diagIo_next[f] = devLocal_reg[f][bgc_pkg::DEV_DIAGIO_BIT];
            flags = modeFlags(devLocal_reg[f][bgc_pkg::DEV_MODE_LSB +: 2]);
            parIrq_next[f] = flags[2];
            serIrq_next[f] = flags[1];
            serPci_next[f] = flags[0];
            if (diagLocal_reg[f][bgc_pkg::DIAG_CSC_BIT])
                csc_next[f] = (legacy805Hi[f] == bgc_pkg::LEGACY_805_PCI_ROUTE);
            else
                csc_next[f] = legacy803Bit4[f];
            zvEn_next[f] = ~diagLocal_reg[f][bgc_pkg::DIAG_ZVOFF_BIT];
        end
        lowVolt_next = devGlobal_reg[bgc_pkg::DEV_LOWVOLT_BIT];
        idMask_next  = diagGlobal_reg[bgc_pkg::DIAG_IDMASK_BIT];
        dlyOff_next  = diagGlobal_reg[bgc_pkg::DIAG_DLYOFF_BIT];
        retry_next   = diagGlobal_reg[bgc_pkg::DIAG_RETRY_BIT] ?
                       bgc_pkg::RETRY_LIMIT_LONG : bgc_pkg::RETRY_LIMIT_SHORT;
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            allow_reg   <= 2'h0;
            lowVolt_reg <= 1'b0;
            diagIo_reg  <= 2'h0;
            parIrq_reg  <= 2'h0;
            serIrq_reg  <= 2'h0;
            serPci_reg  <= 2'h0;
            idMask_reg  <= 1'b0;
            csc_reg     <= 2'h0;
            dlyOff_reg  <= 1'b0;
            retry_reg   <= bgc_pkg::RETRY_LIMIT_SHORT;
            zvEn_reg    <= 2'h0;
        end
        else
        begin
            allow_reg   <= allow_next;
            lowVolt_reg <= lowVolt_next;
            diagIo_reg  <= diagIo_next;
            parIrq_reg  <= parIrq_next;
            serIrq_reg  <= serIrq_next;
            serPci_reg  <= serPci_next;
            idMask_reg  <= idMask_next;
            csc_reg     <= csc_next;
            dlyOff_reg  <= dlyOff_next;
            retry_reg   <= retry_next;
            zvEn_reg    <= zvEn_next;
        end
    end

    assign pwrDownAllow         = allow_reg;
    assign lowVoltCapable       = lowVolt_reg;
    assign diagIoBit            = diagIo_reg;
    assign parallelIrqEn        = parIrq_reg;
    assign serialIrqEn          = serIrq_reg;
    assign serialPciEn          = serPci_reg;
    assign idReadMask           = idMask_reg;
    assign cscToPci             = csc_reg;
    assign delayedTxnDisable    = dlyOff_reg;
    assign retryLatencyLimit    = retry_reg;
    assign zoomVideoModelEnable = zvEn_reg;

    // ------------------------------------------------------------
    // Discard timers
    // ------------------------------------------------------------
    bgc_discard_if cardIf ();
    bgc_discard_if hostIf ();

    assign cardIf.run      = cardDiscardRun;
    assign cardIf.shortSel = diagGlobal_reg[bgc_pkg::DIAG_CARDSEL_BIT];
    assign hostIf.run      = hostDiscardRun;
    assign hostIf.shortSel = diagGlobal_reg[bgc_pkg::DIAG_HOSTSEL_BIT];

    bgc_discard_timer #(.SHORT_CYCLES(DISCARD_SHORT), .LONG_CYCLES(DISCARD_LONG)) cardTimer (
        .mclk (mclk),
        .rst  (rst),
        .tif  (cardIf.tmr)
    );

    bgc_discard_timer #(.SHORT_CYCLES(DISCARD_SHORT), .LONG_CYCLES(DISCARD_LONG)) hostTimer (
        .mclk (mclk),
        .rst  (rst),
        .tif  (hostIf.tmr)
    );

    assign cardDiscardExpired = cardIf.expired;
    assign hostDiscardExpired = hostIf.expired;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    hold_refuse_a: assert property (@(posedge mclk) disable iff (rst)
        (inD3[0] && pwrDownReq[0] && devLocal_reg[0][bgc_pkg::DEV_HOLD_BIT])
        |=> !pwrDownAllow[0])
        else $error("Socket power-down allowed while held in D3");
    volt_report_a: assert property (@(posedge mclk) disable iff (rst)
        (cfgWrEn && !cfgFunc && cfgAddr == bgc_pkg::DEV_CTRL_OFS)
        |=> ##1 lowVoltCapable == $past(cfgWrData[bgc_pkg::DEV_LOWVOLT_BIT], 2))
        else $error("Low-voltage capability does not follow written bit");
    ctrl_rsvd_a: assert property (@(posedge mclk) disable iff (rst)
        (cfgRdEn && cfgAddr == bgc_pkg::DEV_CTRL_OFS)
        |=> cfgRdValid && !cfgRdData[bgc_pkg::DEV_RSVD_BIT])
        else $error("Control bit 4 read as one");
    diag_one_a: assert property (@(posedge mclk) disable iff (rst)
        (cfgRdEn && cfgAddr == bgc_pkg::DIAG_OFS)
        |=> cfgRdData[bgc_pkg::DIAG_ONE_BIT])
        else $error("Diagnostic bit 6 read as zero");
    mode_decode_a: assert property (@(posedge mclk) disable iff (rst)
        serialPciEn[0] |-> serialIrqEn[0] && !parallelIrqEn[0])
        else $error("Inconsistent interrupt signaling flags");
    shared_guard_a: assert property (@(posedge mclk) disable iff (rst)
        (cfgWrEn && cfgFunc) |=> $stable(diagGlobal_reg) && $stable(devGlobal_reg))
        else $error("Function 1 altered a shared bit");
    id_mask_a: assert property (@(posedge mclk) disable iff (rst)
        (cfgWrEn && !cfgFunc && cfgAddr == bgc_pkg::DIAG_OFS)
        |=> ##1 idReadMask == $past(cfgWrData[bgc_pkg::DIAG_IDMASK_BIT], 2))
        else $error("ID mask does not follow written bit");
    retry_limit_a: assert property (@(posedge mclk) disable iff (rst)
        (cfgWrEn && !cfgFunc && cfgAddr == bgc_pkg::DIAG_OFS)
        |=> ##1 retryLatencyLimit == ($past(cfgWrData[bgc_pkg::DIAG_RETRY_BIT], 2) ?
                bgc_pkg::RETRY_LIMIT_LONG : bgc_pkg::RETRY_LIMIT_SHORT))
        else $error("Retry latency limit wrong");
    cap_const_a: assert property (@(posedge mclk) disable iff (rst)
        (cfgRdEn && cfgAddr == bgc_pkg::CAP_ID_OFS) |=> cfgRdData == 8'h01)
        else $error("Capability identifier not 01h");
    next_ptr_a: assert property (@(posedge mclk) disable iff (rst)
        (cfgRdEn && cfgAddr == bgc_pkg::NEXT_PTR_OFS) |=> cfgRdData == 8'h00)
        else $error("Next-item pointer not zero");
endmodule

// [sim/bgc_global_config_regs_bench.sv]
`timescale 1ns/10ps
module bgc_global_config_regs_bench;
    // ----------------------------------------
    // Signals and device under test
    // ----------------------------------------
    logic       mclk, rst, cfgFunc, cfgWrEn, cfgRdEn, cfgRdValid, cfgHit, lowVoltCapable;
    logic       idReadMask, delayedTxnDisable, cardDiscardRun, hostDiscardRun;
    logic       cardDiscardExpired, hostDiscardExpired;
    logic [7:0] cfgAddr, cfgWrData, cfgRdData;
    logic [1:0] pwrDownReq, inD3, pwrDownAllow, diagIoBit, parallelIrqEn, serialIrqEn;
    logic [1:0] serialPciEn, legacy803Bit4, cscToPci, zoomVideoModelEnable;
    logic [3:0] legacy805Hi0, legacy805Hi1;
    logic [6:0] retryLatencyLimit;
    int         err_count, total_checks;

    // Short discard counts keep the run brief
    bgc_global_config_regs #(.DISCARD_SHORT(8), .DISCARD_LONG(32)) DUT (
        .mclk(mclk), .rst(rst), .cfgFunc(cfgFunc), .cfgAddr(cfgAddr), .cfgWrData(cfgWrData),
        .cfgWrEn(cfgWrEn), .cfgRdEn(cfgRdEn), .cfgRdData(cfgRdData), .cfgRdValid(cfgRdValid),
        .cfgHit(cfgHit), .pwrDownReq(pwrDownReq), .inD3(inD3), .pwrDownAllow(pwrDownAllow),
        .lowVoltCapable(lowVoltCapable), .diagIoBit(diagIoBit), .parallelIrqEn(parallelIrqEn),
        .serialIrqEn(serialIrqEn), .serialPciEn(serialPciEn), .idReadMask(idReadMask),
        .legacy803Bit4(legacy803Bit4), .legacy805Hi0(legacy805Hi0),
        .legacy805Hi1(legacy805Hi1), .cscToPci(cscToPci),
        .delayedTxnDisable(delayedTxnDisable), .retryLatencyLimit(retryLatencyLimit),
        .cardDiscardRun(cardDiscardRun), .hostDiscardRun(hostDiscardRun),
        .cardDiscardExpired(cardDiscardExpired), .hostDiscardExpired(hostDiscardExpired),
        .zoomVideoModelEnable(zoomVideoModelEnable)
    );

    `define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin err_count++; \
        $display("BAD %s exp %0h got %0h", nm, e, g); end end

    // Clock, 100 ns period
    always #50 mclk = ~mclk;

    // ----------------------------------------
    // Access tasks, driven on falling edges
    // ----------------------------------------
    task wr(input logic f, input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk);
        cfgFunc = f; cfgAddr = a; cfgWrData = d; cfgWrEn = 1'b1;
        @(negedge mclk);
        cfgWrEn = 1'b0;
    endtask

    // Read answer is valid one cycle after the strobe edge
    task rd(input logic f, input logic [7:0] a, input logic [7:0] e, input logic h);
        @(negedge mclk);
        cfgFunc = f; cfgAddr = a; cfgRdEn = 1'b1;
        @(negedge mclk);
        cfgRdEn = 1'b0;
        `CHK("valid", 1'b1, cfgRdValid)
        `CHK("hit", h, cfgHit)
        `CHK("rdata", e, cfgRdData)
    endtask

    // Decoded outputs lag the register by one cycle
    task settle;
        repeat (2) @(negedge mclk);
    endtask

    // Count falling edges from run high until the expiry pulse shows
    task disc(input logic card, input int n);
        int k;
        @(negedge mclk);
        if (card) cardDiscardRun = 1'b1; else hostDiscardRun = 1'b1;
        k = 0;
        while (k < 200 && (card ? cardDiscardExpired : hostDiscardExpired) !== 1'b1)
        begin
            @(negedge mclk);
            k++;
        end
        `CHK("discard", n, k)
        cardDiscardRun = 1'b0;
        hostDiscardRun = 1'b0;
    endtask

    task print_verdict;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // Watchdog well beyond the under two hundred cycles the tests take
    initial
    begin
        repeat (5000) @(posedge mclk);
        err_count++;
        print_verdict();
    end

    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial
    begin
        mclk = 0; rst = 1; cfgFunc = 0; cfgAddr = 0; cfgWrData = 0; cfgWrEn = 0; cfgRdEn = 0;
        pwrDownReq = 2'h3; inD3 = 2'h3; legacy803Bit4 = 2'h2; legacy805Hi0 = 4'h0;
        legacy805Hi1 = 4'h3; cardDiscardRun = 0; hostDiscardRun = 0;
        err_count = 0; total_checks = 0;
        repeat (20) @(negedge mclk);
        rst = 0;
        settle();
        rd(0, bgc_pkg::DEV_CTRL_OFS, 8'h66, 1);
        rd(1, bgc_pkg::DEV_CTRL_OFS, 8'h26, 1);
        rd(0, bgc_pkg::DIAG_OFS, 8'h60, 1);
        rd(1, bgc_pkg::DIAG_OFS, 8'h60, 1);
        `CHK("lowvolt", 1'b1, lowVoltCapable)
        `CHK("zoom", 2'h3, zoomVideoModelEnable)
        `CHK("retry", 7'h10, retryLatencyLimit)
        `CHK("idmask", 1'b0, idReadMask)
        `CHK("pwr", 2'h3, pwrDownAllow)
        $display("reset test done");
        // Fixed bytes and unmapped offset ignore writes
        wr(0, bgc_pkg::CAP_ID_OFS, 8'hFF);
        wr(0, bgc_pkg::NEXT_PTR_OFS, 8'hFF);
        wr(0, 8'h94, 8'hFF);
        rd(0, bgc_pkg::CAP_ID_OFS, 8'h01, 1);
        rd(1, bgc_pkg::NEXT_PTR_OFS, 8'h00, 1);
        rd(0, 8'h94, 8'h00, 0);
        // Bit 4 reads zero; function 1 cannot touch shared bits; test bits kept zero
        wr(0, bgc_pkg::DEV_CTRL_OFS, 8'hF6);
        wr(1, bgc_pkg::DEV_CTRL_OFS, 8'h00);
        rd(0, bgc_pkg::DEV_CTRL_OFS, 8'hE6, 1);
        rd(1, bgc_pkg::DEV_CTRL_OFS, 8'h00, 1);
        settle();
        `CHK("lowvolt", 1'b1, lowVoltCapable)
        `CHK("diagio", 2'h1, diagIoBit)
        `CHK("pwr", 2'h2, pwrDownAllow)
        $display("access test done");
        // Every signaling mode through function 0; function 1 copy stays
        for (int m = 0; m < 4; m++)
        begin
            wr(0, bgc_pkg::DEV_CTRL_OFS, {5'h00, m[1:0], 1'b0});
            settle();
            `CHK("par", (m == 1), parallelIrqEn[0])
            `CHK("ser", m[1], serialIrqEn[0])
            `CHK("serpci", (m == 3), serialPciEn[0])
        end
        `CHK("ser", 2'h1, serialIrqEn)
        `CHK("serpci", 2'h1, serialPciEn)
        `CHK("lowvolt", 1'b0, lowVoltCapable)
        `CHK("pwr", 2'h3, pwrDownAllow)
        $display("mode test done");
        // Diagnostic bits and routing
        wr(0, bgc_pkg::DIAG_OFS, 8'h9F);
        rd(0, bgc_pkg::DIAG_OFS, 8'hDF, 1);
        settle();
        `CHK("idmask", 1'b1, idReadMask)
        `CHK("dly", 1'b1, delayedTxnDisable)
        `CHK("retry", 7'h40, retryLatencyLimit)
        `CHK("zoom", 2'h2, zoomVideoModelEnable)
        `CHK("csc", 2'h0, cscToPci)
        wr(0, bgc_pkg::DIAG_OFS, 8'h02);
        legacy803Bit4 = 2'h1;
        legacy805Hi1 = 4'h0;
        settle();
        `CHK("csc", 2'h3, cscToPci)
        `CHK("dly", 1'b0, delayedTxnDisable)
        $display("diag test done");
        // Host short, card long, then card short and host long
        disc(0, 8);
        disc(1, 32);
        wr(0, bgc_pkg::DIAG_OFS, 8'h04);
        settle();
        disc(1, 8);
        disc(0, 32);
        // Leave the diagnostic register at zero, as software should
        wr(0, bgc_pkg::DIAG_OFS, 8'h00);
        rd(0, bgc_pkg::DIAG_OFS, 8'h40, 1);
        $display("timer test done");
        print_verdict();
    end
endmodule
